// ==== rdd_consts.vh ====
`ifndef RDD_CONSTS_VH
`define RDD_CONSTS_VH

// ****************************************
// register offsets (word index on the plain port)
// ****************************************
`define RDD_REG_CTRL      4'h0
`define RDD_REG_RING_LO   4'h1
`define RDD_REG_RING_HI   4'h2
`define RDD_REG_STATUS    4'h3
`define RDD_REG_FRAMES    4'h4
`define RDD_REG_DROPS     4'h5

// ****************************************
// control fields and reset values
// ****************************************
`define RDD_CTRL_EN_BIT   0
`define RDD_CTRL_JAP_BIT  1
`define RDD_CTRL_RST      2'h0
`define RDD_RING_LO_RST   16'h0000
`define RDD_RING_HI_RST   8'h00
`define RDD_RLEN_RST      3'h0
`define RDD_RLEN_LO       8
`define RDD_RLEN_HI       10
`define RDD_JAP_SELECT    1'h1

// ****************************************
// status fields
// ****************************************
`define RDD_STAT_BUSY_BIT 0
`define RDD_STAT_WAIT_BIT 1
`define RDD_STAT_IDX_LO   8
`define RDD_STAT_IDX_HI   14

// ****************************************
// descriptor layout
// ****************************************
`define RDD_OWN_BIT       15
`define RDD_SEC_BIT       14
`define RDD_FIRST_BIT     13
`define RDD_LAST_BIT      12
`define RDD_PRIO_HI       11
`define RDD_PRIO_LO       10
`define RDD_RSV_HI        9
`define RDD_RSV_LO        8
`define RDD_ADRHI_HI      7
`define RDD_W0_OFS        24'h000000
`define RDD_W1_OFS        24'h000002
`define RDD_W2_OFS        24'h000004
`define RDD_W3_OFS        24'h000006
`define RDD_WORD_STEP     24'h000002
`define RDD_DESC_SHIFT    3

`endif

// ==== rdd_counter.v ====
`timescale 1ns/1ps

// ****************************************
// clearable up counter
// ****************************************
module rdd_counter #(
	parameter W = 16
) (
	// clock and reset
	input  wire         clk,
	input  wire         sysRst,
	// control
	input  wire         clr,
	input  wire         inc,
	// value
	output reg  [W-1:0] q_ff
);

	always @(posedge clk) begin
		if (sysRst || clr) begin
			q_ff <= {W{1'b0}};
		end else if (inc) begin
			q_ff <= q_ff + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule // rdd_counter

// ==== rdd_pair_buf.v ====
`timescale 1ns/1ps

// ****************************************
// two-entry buffer, registered ready
// ****************************************
module rdd_pair_buf #(
	parameter W = 12
) (
	// clock and reset
	input  wire         clk,
	input  wire         sysRst,
	// fill side
	input  wire [W-1:0] inData,
	input  wire         inValid,
	output reg          inReady_ff,
	// drain side
	output wire [W-1:0] outData,
	output wire         outValid,
	input  wire         outReady
);

	reg  [W-1:0] ent0_ff;
	reg  [W-1:0] ent1_ff;
	reg  [1:0]   cnt_ff;
	wire         push;
	wire         pop;
	reg  [1:0]   nxt_cnt;

	assign outData  = ent0_ff;
	assign outValid = (cnt_ff != 2'h0);
	assign push     = inValid && inReady_ff;
	assign pop      = outValid && outReady;

	always @* begin
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 2'h1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 2'h1;
		end
	end

	// ready from a flop so a stall never reaches back combinationally
	always @(posedge clk) begin
		if (sysRst) begin
			cnt_ff     <= 2'h0;
			inReady_ff <= 1'b0;
			ent0_ff    <= {W{1'b0}};
			ent1_ff    <= {W{1'b0}};
		end else begin
			cnt_ff     <= nxt_cnt;
			inReady_ff <= (nxt_cnt != 2'h2);
			if (pop) begin
				ent0_ff <= (push && cnt_ff == 2'h1) ? inData : ent1_ff;
				if (push && cnt_ff == 2'h2) begin
					ent1_ff <= inData;
				end
			end else if (push) begin
				if (cnt_ff == 2'h0) begin
					ent0_ff <= inData;
				end else begin
					ent1_ff <= inData;
				end
			end
		end
	end

endmodule // rdd_pair_buf

// ==== rdd_rx_desc_dma.v ====
`timescale 1ns/1ps
`include "rdd_consts.vh"

module rdd_rx_desc_dma (
	// clock and reset
	input  wire        clk,
	input  wire        sysRst,
	// register port
	input  wire [3:0]  regAddr,
	input  wire [15:0] regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [15:0] regRdData_ff,
	// received-frame stream
	input  wire [7:0]  rxData,
	input  wire        rxLast,
	input  wire        rxGood,
	input  wire [1:0]  rxPrio,
	input  wire        rxValid,
	output wire        rxReady,
	// memory bus master
	output reg         memReq_ff,
	output reg         memWe_ff,
	output reg  [23:0] memAddr_ff,
	output reg  [15:0] memWrData_ff,
	input  wire [15:0] memRdData,
	input  wire        memAck
);

	// ****************************************
	// states
	// ****************************************
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_RD0  = 4'h1;
	localparam [3:0] S_RD1  = 4'h2;
	localparam [3:0] S_RD2  = 4'h3;
	localparam [3:0] S_FILL = 4'h4;
	localparam [3:0] S_WRD  = 4'h5;
	localparam [3:0] S_WR3  = 4'h6;
	localparam [3:0] S_WR0  = 4'h7;
	localparam [1:0] K_NONE  = 2'h0;
	localparam [1:0] K_CHAIN = 2'h1;
	localparam [1:0] K_END   = 2'h2;

	// ****************************************
	// registers
	// ****************************************
	reg  [1:0]  ctrl_ff;
	reg  [15:0] ringLo_ff;
	reg  [7:0]  ringHi_ff;
	reg  [2:0]  ringLen_ff;
	reg  [3:0]  state_ff;
	reg  [6:0]  idx_ff;
	reg  [15:0] rxDescWord0_ff;
	reg  [23:0] bufPtr_ff;
	reg  [15:0] bufLen_ff;
	reg  [7:0]  lowByte_ff;
	reg  [7:0]  highByte_ff;
	reg         half_ff;
	reg  [1:0]  kind_ff;
	reg         firstFlag_ff;
	reg         goodFrame_ff;
	reg  [1:0]  prio_ff;
	reg         waitDesc_ff;
	wire [15:0] msgCount;
	wire [15:0] bufUsed;
	wire [15:0] frameCount;
	wire [15:0] dropCount;
	wire [11:0] bufOutData;
	wire        bufOutValid;
	wire        byteTake;
	wire        accDone;
	wire [6:0]  idxMask;
	wire [23:0] ringBase;
	wire [23:0] descBase;
	wire        japanMode;
	wire        frameDone;
	wire        frameDrop;
	wire        unitStart;
	reg  [15:0] word0Out;

	assign japanMode = (ctrl_ff[`RDD_CTRL_JAP_BIT] == `RDD_JAP_SELECT);
	assign idxMask   = (7'h01 << ringLen_ff) - 7'h01;
	assign ringBase  = {ringHi_ff, ringLo_ff};
	assign descBase  = ringBase + ({17'h00000, idx_ff} << `RDD_DESC_SHIFT);
	assign accDone   = memReq_ff && memAck;
	assign byteTake  = (state_ff == S_FILL) && bufOutValid;
	assign frameDone = (state_ff == S_WR0) && accDone && (kind_ff == K_END);
	assign frameDrop = (state_ff == S_WRD) && accDone && (kind_ff == K_END) && !goodFrame_ff;
	assign unitStart = (state_ff == S_IDLE) && bufOutValid && ctrl_ff[`RDD_CTRL_EN_BIT];

	// ****************************************
	// stream buffer and counters
	// ****************************************
	rdd_pair_buf #(.W(12)) u_buf (
		.clk      (clk),
		.sysRst   (sysRst),
		.inData   ({rxPrio, rxGood, rxLast, rxData}),
		.inValid  (rxValid),
		.inReady_ff(rxReady),
		.outData  (bufOutData),
		.outValid (bufOutValid),
		.outReady (byteTake)
	);
	rdd_counter #(.W(16)) u_msg (
		.clk    (clk),
		.sysRst (sysRst),
		.clr    (unitStart),
		.inc    (byteTake),
		.q_ff   (msgCount)
	);
	rdd_counter #(.W(16)) u_used (
		.clk    (clk),
		.sysRst (sysRst),
		.clr    (state_ff == S_RD2),
		.inc    (byteTake),
		.q_ff   (bufUsed)
	);
	rdd_counter #(.W(16)) u_frames (
		.clk    (clk),
		.sysRst (sysRst),
		.clr    (1'b0),
		.inc    (frameDone),
		.q_ff   (frameCount)
	);
	rdd_counter #(.W(16)) u_drops (
		.clk    (clk),
		.sysRst (sysRst),
		.clr    (1'b0),
		.inc    (frameDrop),
		.q_ff   (dropCount)
	);

	// ****************************************
	// returned first word
	// ****************************************
	always @* begin
		word0Out = rxDescWord0_ff;
		word0Out[`RDD_OWN_BIT]   = 1'b0;
		word0Out[`RDD_FIRST_BIT] = firstFlag_ff;
		word0Out[`RDD_LAST_BIT]  = (kind_ff == K_END);
		if (japanMode) begin
			word0Out[`RDD_PRIO_HI:`RDD_PRIO_LO] = prio_ff;
		end
	end

	// ****************************************
	// register port
	// ****************************************
	always @(posedge clk) begin
		if (sysRst) begin
			ctrl_ff    <= `RDD_CTRL_RST;
			ringLo_ff  <= `RDD_RING_LO_RST;
			ringHi_ff  <= `RDD_RING_HI_RST;
			ringLen_ff <= `RDD_RLEN_RST;
		end else if (regWr) begin
			case (regAddr)
				`RDD_REG_CTRL:    ctrl_ff <= regWrData[1:0];
				`RDD_REG_RING_LO: ringLo_ff <= {regWrData[15:1], 1'b0};
				`RDD_REG_RING_HI: begin
					ringHi_ff  <= regWrData[7:0];
					ringLen_ff <= regWrData[`RDD_RLEN_HI:`RDD_RLEN_LO];
				end
				default:          ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	always @(posedge clk) begin
		if (sysRst) begin
			regRdData_ff <= 16'h0000;
		end else if (regRd) begin
			case (regAddr)
				`RDD_REG_CTRL:    regRdData_ff <= {14'h0000, ctrl_ff};
				`RDD_REG_RING_LO: regRdData_ff <= ringLo_ff;
				`RDD_REG_RING_HI: regRdData_ff <= {5'h00, ringLen_ff, ringHi_ff};
				`RDD_REG_STATUS:  regRdData_ff <= {1'b0, idx_ff, 6'h00, waitDesc_ff,
					(state_ff != S_IDLE)};
				`RDD_REG_FRAMES:  regRdData_ff <= frameCount;
				`RDD_REG_DROPS:   regRdData_ff <= dropCount;
				default:          regRdData_ff <= 16'h0000;
			endcase
		end else begin
			regRdData_ff <= 16'h0000;
		end
	end

	// ****************************************
	// descriptor engine
	// ****************************************
	always @(posedge clk) begin
		if (sysRst) begin
			state_ff       <= S_IDLE;
			idx_ff         <= 7'h00;
			rxDescWord0_ff <= 16'h0000;
			bufPtr_ff      <= 24'h000000;
			bufLen_ff      <= 16'h0000;
			lowByte_ff     <= 8'h00;
			highByte_ff    <= 8'h00;
			half_ff        <= 1'b0;
			kind_ff        <= K_NONE;
			firstFlag_ff   <= 1'b0;
			goodFrame_ff   <= 1'b0;
			prio_ff        <= 2'h0;
			waitDesc_ff    <= 1'b0;
			memReq_ff      <= 1'b0;
			memWe_ff       <= 1'b0;
			memAddr_ff     <= 24'h000000;
			memWrData_ff   <= 16'h0000;
		end else begin
			if (accDone) begin
				memReq_ff <= 1'b0;
			end
			case (state_ff)
				S_IDLE: begin
					half_ff <= 1'b0;
					if (unitStart) begin
						firstFlag_ff <= 1'b1;
						state_ff     <= S_RD0;
					end
				end
				S_RD0: begin
					if (!memReq_ff) begin
						memReq_ff  <= 1'b1;
						memWe_ff   <= 1'b0;
						memAddr_ff <= descBase + `RDD_W0_OFS;
					end else if (memAck) begin
						rxDescWord0_ff <= memRdData;
						// host still holds it: poll again, touch nothing
						waitDesc_ff <= !memRdData[`RDD_OWN_BIT];
						if (memRdData[`RDD_OWN_BIT]) begin
							state_ff <= S_RD1;
						end
					end
				end
				S_RD1: begin
					if (!memReq_ff) begin
						memReq_ff  <= 1'b1;
						memAddr_ff <= descBase + `RDD_W1_OFS;
					end else if (memAck) begin
						bufPtr_ff <= {rxDescWord0_ff[`RDD_ADRHI_HI:0],
							memRdData[15:1], 1'b0};
						state_ff  <= S_RD2;
					end
				end
				S_RD2: begin
					if (!memReq_ff) begin
						memReq_ff  <= 1'b1;
						memAddr_ff <= descBase + `RDD_W2_OFS;
					end else if (memAck) begin
						bufLen_ff <= 16'h0000 - memRdData;
						state_ff  <= S_FILL;
					end
				end
				S_FILL: begin
					if (byteTake) begin
						half_ff <= !half_ff;
						if (!half_ff) begin
							lowByte_ff <= bufOutData[7:0];
						end else begin
							highByte_ff <= bufOutData[7:0];
						end
						if (bufOutData[8]) begin
							kind_ff      <= K_END;
							goodFrame_ff <= bufOutData[9];
							prio_ff      <= bufOutData[11:10];
							state_ff     <= S_WRD;
						end else if (half_ff) begin
							// length is even, so a full buffer ends on a word
							kind_ff  <= (bufUsed + 16'h0001 == bufLen_ff) ? K_CHAIN : K_NONE;
							state_ff <= S_WRD;
						end
					end
				end
				S_WRD: begin
					if (!memReq_ff) begin
						memReq_ff    <= 1'b1;
						memWe_ff     <= 1'b1;
						memAddr_ff   <= bufPtr_ff;
						// first byte in the low lane; odd tail pads zero
						memWrData_ff <= half_ff ? {8'h00, lowByte_ff}
							: {highByte_ff, lowByte_ff};
					end else if (memAck) begin
						half_ff   <= 1'b0;
						bufPtr_ff <= bufPtr_ff + `RDD_WORD_STEP;
						case (kind_ff)
							K_NONE:  state_ff <= S_FILL;
							K_CHAIN: state_ff <= S_WR0;
							// bad unit: descriptor stays with us and is reused
							K_END:   state_ff <= goodFrame_ff ? S_WR3 : S_IDLE;
							default: state_ff <= S_IDLE;
						endcase
					end
				end
				S_WR3: begin
					if (!memReq_ff) begin
						memReq_ff    <= 1'b1;
						memWe_ff     <= 1'b1;
						memAddr_ff   <= descBase + `RDD_W3_OFS;
						memWrData_ff <= 16'h0000 - msgCount;
					end else if (memAck) begin
						state_ff <= S_WR0;
					end
				end
				S_WR0: begin
					if (!memReq_ff) begin
						memReq_ff    <= 1'b1;
						memWe_ff     <= 1'b1;
						memAddr_ff   <= descBase + `RDD_W0_OFS;
						memWrData_ff <= word0Out;
					end else if (memAck) begin
						// ownership is gone: advance, never touch it again
						idx_ff       <= (idx_ff + 7'h01) & idxMask;
						firstFlag_ff <= 1'b0;
						kind_ff      <= K_NONE;
						state_ff     <= (kind_ff == K_END) ? S_IDLE : S_RD0;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

endmodule // rdd_rx_desc_dma

// ==== rdd_rx_desc_dma_properties.sv ====
`timescale 1ns/1ps
`include "rdd_consts.vh"

// **********
// port checker
// **********
module rdd_rx_desc_dma_properties (
	// clock and reset
	input wire        clk,
	input wire        sysRst,
	// register and stream inputs
	input wire [3:0]  regAddr,
	input wire [15:0] regWrData,
	input wire        regWr,
	input wire        rxValid,
	input wire        rxLast,
	input wire [1:0]  rxPrio,
	input wire        rxReady,
	// memory bus
	input wire        memReq_ff,
	input wire        memWe_ff,
	input wire [23:0] memAddr_ff,
	input wire [15:0] memWrData_ff,
	input wire [15:0] memRdData,
	input wire        memAck
);
	reg  [23:0] d0A_ff;
	reg  [23:0] lastA_ff;
	reg  [15:0] d0D_ff;
	reg  [1:0]  prio_ff;
	reg         jap_ff;
	reg         first_ff;
	wire        rdAck = memReq_ff & memAck & ~memWe_ff;
	wire        wrAck = memReq_ff & memAck & memWe_ff;
	wire        w0Rd  = rdAck & (memAddr_ff != lastA_ff + 24'h000002);
	wire        w0Wr  = wrAck & (memAddr_ff == d0A_ff);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sysRst);

	// a read not following its neighbour starts a descriptor
	// limitation: assumes one unit in flight and buffers away from the ring
	always @(posedge clk) begin
		// cleared so the first descriptor of the run is tracked too
		if (sysRst) begin
			lastA_ff <= 24'h000000;
			d0A_ff   <= 24'h000000;
			d0D_ff   <= 16'h0000;
		end else begin
			if (rdAck) lastA_ff <= memAddr_ff;
			if (w0Rd) d0A_ff <= memAddr_ff;
			if (w0Rd) d0D_ff <= memRdData;
		end
		if (rxValid && rxReady && rxLast) prio_ff <= rxPrio;
		if (sysRst) jap_ff <= 1'b0;
		else if (regWr && regAddr == `RDD_REG_CTRL) jap_ff <= regWrData[`RDD_CTRL_JAP_BIT];
		if (sysRst) first_ff <= 1'b1;
		else if (w0Wr) first_ff <= memWrData_ff[12];
	end

	property p_even; memReq_ff |-> !memAddr_ff[0]; endproperty
	a_even: assert property (p_even) else $error("odd address");
	property p_hold; memReq_ff && !memAck |=> memReq_ff && $stable(memAddr_ff)
		&& $stable(memWe_ff) && $stable(memWrData_ff); endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_rel; w0Wr |-> !memWrData_ff[15] && memWrData_ff[14] == d0D_ff[14]
		&& memWrData_ff[9:0] == d0D_ff[9:0]; endproperty
	a_rel: assert property (p_rel) else $error("bad word0 writeback");
	property p_prio; w0Wr && memWrData_ff[12] |->
		memWrData_ff[11:10] == (jap_ff ? prio_ff : d0D_ff[11:10]); endproperty
	a_prio: assert property (p_prio) else $error("bad priority");
	property p_poll; w0Rd && !memRdData[15] |=> !(memReq_ff && memWe_ff) [*4]; endproperty
	a_poll: assert property (p_poll) else $error("write on host descriptor");
	property p_first; w0Wr |-> memWrData_ff[13] == first_ff; endproperty
	a_first: assert property (p_first) else $error("bad first flag");
	property p_last; wrAck && memAddr_ff == d0A_ff + 24'h000006 |->
		##[1:60] (w0Wr && memWrData_ff[12]); endproperty
	a_last: assert property (p_last) else $error("no last word0");
	property p_keep; wrAck |-> memAddr_ff != d0A_ff + 24'h000002
		&& memAddr_ff != d0A_ff + 24'h000004; endproperty
	a_keep: assert property (p_keep) else $error("host word written");

	c_chain: cover property (w0Wr && !memWrData_ff[12]);
	c_poll: cover property (w0Rd && !memRdData[15]);
	c_stall: cover property (rxValid && !rxReady);
endmodule // rdd_rx_desc_dma_properties

// ==== rdd_mem_model.sv ====
`timescale 1ns/1ps

// **********
// host memory, paced acknowledge
// **********
module rdd_mem_model (
	// clock
	input  wire        clk,
	// memory bus
	input  wire        memReq,
	input  wire        memWe,
	input  wire [23:0] memAddr,
	input  wire [15:0] memWrData,
	output wire [15:0] memRdData,
	output wire        memAck,
	// pacing
	input  wire [3:0]  waitCycles
);
	reg [15:0] mem [0:1023];
	reg [15:0] rdWord_ff = 16'h0000;
	reg [3:0]  wait_ff = 4'h0;
	reg        ack_ff = 1'b0;

	// only ten address bits decode, upper bits alias
	assign memAck    = ack_ff;
	// off-ack data never repeats the last word
	assign memRdData = ack_ff ? rdWord_ff : ~rdWord_ff;

	always @(posedge clk) begin
		ack_ff <= 1'b0;
		if (memReq && ack_ff && memWe) mem[memAddr[10:1]] <= memWrData;
		if (memReq && !ack_ff && wait_ff == waitCycles) begin
			ack_ff    <= 1'b1;
			rdWord_ff <= mem[memAddr[10:1]];
			wait_ff   <= 4'h0;
		end else if (memReq && !ack_ff) begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule // rdd_mem_model

// ==== rdd_rx_desc_dma_tb_top.sv ====
`timescale 1ns/1ps
`include "rdd_consts.vh"

// **********
// bench top
// **********
module rdd_rx_desc_dma_tb_top;
	localparam DB = 10'h080;
	reg         clk = 1'b0;
	reg         sysRst = 1'b1;
	reg  [3:0]  regAddr = 4'h0;
	reg  [15:0] regWrData = 16'h0000;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg  [7:0]  rxData = 8'h00;
	reg         rxLast = 1'b0;
	reg         rxGood = 1'b0;
	reg  [1:0]  rxPrio = 2'h0;
	reg         rxValid = 1'b0;
	reg  [3:0]  waitCycles = 4'h0;
	reg         sawStall = 1'b0;
	wire [15:0] regRdData_ff;
	wire        rxReady;
	wire        memReq_ff;
	wire        memWe_ff;
	wire [23:0] memAddr_ff;
	wire [15:0] memWrData_ff;
	wire [15:0] memRdData;
	wire        memAck;
	integer     miscompares = 0;
	integer     samplesChecked = 0;
	integer     cycles = 0;

	rdd_rx_desc_dma uut (
		.clk(clk), .sysRst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff), .rxData(rxData),
		.rxLast(rxLast), .rxGood(rxGood), .rxPrio(rxPrio), .rxValid(rxValid),
		.rxReady(rxReady), .memReq_ff(memReq_ff), .memWe_ff(memWe_ff),
		.memAddr_ff(memAddr_ff), .memWrData_ff(memWrData_ff),
		.memRdData(memRdData), .memAck(memAck));
	rdd_mem_model u_mem (
		.clk(clk), .memReq(memReq_ff), .memWe(memWe_ff), .memAddr(memAddr_ff),
		.memWrData(memWrData_ff), .memRdData(memRdData), .memAck(memAck),
		.waitCycles(waitCycles));

	initial begin
		forever #50 clk = ~clk;
	end

	task completeRun;
		begin
			$display("compared %0d, mismatched %0d", samplesChecked, miscompares);
			if (miscompares == 0 && samplesChecked > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	// hang guard, a few hundred cycles are expected
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			completeRun;
		end
	end

	task chk(input [15:0] got, input [15:0] exp);
		begin
			samplesChecked = samplesChecked + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// extra edge keeps the strobe from being set twice in one step
	task regW(input [3:0] a, input [15:0] d);
		begin
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
			@(posedge clk);
			regWr <= 1'b0;
			@(posedge clk);
		end
	endtask

	task regR(input [3:0] a, input [15:0] exp);
		begin
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge clk);
			regRd <= 1'b0;
			@(posedge clk);
			chk(regRdData_ff, exp);
		end
	endtask

	task sendUnit(input integer n, input good, input [1:0] pr);
		integer i;
		integer t;
		begin
			for (i = 0; i < n; i = i + 1) begin
				rxData <= 8'h11 + i[7:0];
				rxLast <= (i == n - 1);
				rxGood <= good;
				rxPrio <= pr;
				rxValid <= 1'b1;
				t = 0;
				@(posedge clk);
				while (rxReady !== 1'b1 && t < 500) begin
					sawStall = 1'b1;
					@(posedge clk);
					t = t + 1;
				end
			end
			rxValid <= 1'b0;
		end
	endtask

	// bits 11:8 left zero by the host side
	task setDesc(input integer i, input own, input [15:0] len);
		begin
			u_mem.mem[DB + 4 * i] = {own, 7'h40, 8'h5A};
			u_mem.mem[DB + 4 * i + 1] = 16'h0200 + 16'h0040 * i[15:0];
			u_mem.mem[DB + 4 * i + 2] = 16'h0000 - len;
			u_mem.mem[DB + 4 * i + 3] = 16'h0000;
		end
	endtask

	task chkDesc(input integer i, input f, input l, input [1:0] pr, input [15:0] len,
		input [15:0] mlen);
		begin
			chk(u_mem.mem[DB + 4 * i], {2'b01, f, l, pr, 2'b00, 8'h5A});
			chk(u_mem.mem[DB + 4 * i + 1], 16'h0200 + 16'h0040 * i[15:0]);
			chk(u_mem.mem[DB + 4 * i + 2], 16'h0000 - len);
			chk(u_mem.mem[DB + 4 * i + 3], 16'h0000 - mlen);
		end
	endtask

	task waitRel(input integer i);
		integer t;
		begin
			t = 0;
			while (u_mem.mem[DB + 4 * i][15] !== 1'b0 && t < 3000) begin
				@(posedge clk);
				t = t + 1;
			end
		end
	endtask

	task runRegs;
		begin
			regR(`RDD_REG_CTRL, 16'h0000);
			regR(4'hF, 16'h0000);
			regW(`RDD_REG_STATUS, 16'hFFFF);
			regR(`RDD_REG_STATUS, 16'h0000);
			regW(`RDD_REG_RING_LO, 16'h0101);
			regR(`RDD_REG_RING_LO, 16'h0100);
			regW(`RDD_REG_RING_HI, 16'h0200);
			regR(`RDD_REG_RING_HI, 16'h0200);
			regW(`RDD_REG_CTRL, 16'h0001);
			regR(`RDD_REG_CTRL, 16'h0001);
		end
	endtask

	task runSingle;
		begin
			setDesc(0, 1'b1, 16'h0008);
			sendUnit(3, 1'b1, 2'b11);
			waitRel(0);
			chkDesc(0, 1'b1, 1'b1, 2'b00, 16'h0008, 16'h0003);
			chk(u_mem.mem[10'h100], 16'h1211);
			chk(u_mem.mem[10'h101], 16'h0013);
		end
	endtask

	// slow memory makes the two-entry buffer refuse
	task runChain;
		begin
			sawStall = 1'b0;
			setDesc(1, 1'b1, 16'h0004);
			setDesc(2, 1'b1, 16'h0004);
			sendUnit(5, 1'b1, 2'b00);
			waitRel(2);
			chkDesc(1, 1'b1, 1'b0, 2'b00, 16'h0004, 16'h0000);
			chkDesc(2, 1'b0, 1'b1, 2'b00, 16'h0004, 16'h0005);
			chk(u_mem.mem[10'h121], 16'h1413);
			chk(u_mem.mem[10'h140], 16'h0015);
			chk({15'h0000, sawStall}, 16'h0001);
		end
	endtask

	task runJapan;
		begin
			regW(`RDD_REG_CTRL, 16'h0003);
			setDesc(3, 1'b0, 16'h0008);
			sendUnit(2, 1'b1, 2'b10);
			repeat (40) @(posedge clk);
			regR(`RDD_REG_STATUS, 16'h0303);
			chk(u_mem.mem[DB + 12], 16'h405A);
			u_mem.mem[DB + 12] = 16'hC05A;
			waitRel(3);
			chkDesc(3, 1'b1, 1'b1, 2'b10, 16'h0008, 16'h0002);
		end
	endtask

	task runBad;
		begin
			setDesc(0, 1'b1, 16'h0008);
			sendUnit(2, 1'b0, 2'b00);
			repeat (60) @(posedge clk);
			chk(u_mem.mem[DB], 16'hC05A);
			regR(`RDD_REG_DROPS, 16'h0001);
			regR(`RDD_REG_FRAMES, 16'h0003);
		end
	endtask

	initial begin
		repeat (3) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		runRegs;
		runSingle;
		waitCycles <= 4'h3;
		runChain;
		waitCycles <= 4'h0;
		runJapan;
		runBad;
		completeRun;
	end
endmodule // rdd_rx_desc_dma_tb_top

bind rdd_rx_desc_dma rdd_rx_desc_dma_properties u_props (
	.clk(clk), .sysRst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .rxValid(rxValid), .rxLast(rxLast), .rxPrio(rxPrio),
	.rxReady(rxReady), .memReq_ff(memReq_ff), .memWe_ff(memWe_ff),
	.memAddr_ff(memAddr_ff), .memWrData_ff(memWrData_ff),
	.memRdData(memRdData), .memAck(memAck));
